// >>> rtl/rpmc_pkg.sv
// Constants, register map and state codes of the reader power-mode control.
// What this block does
// - Seven power states are chosen by the primary enable pin, the wake enable pin and four bits of the control register at 00h.
// - A high primary enable turns on every regulator and the crystal oscillator and offers the controller clock output.
// - Primary enable low with wake enable high keeps the auxiliary supply on and drives a 60 kHz clock to the controller.
// - Both enables low mean complete power down with nothing running and no clock output.
// - A rising wake enable edge in complete power down starts supplies and oscillator as a high primary enable would, until they settle.
// - The clock output moves from 60 kHz to the crystal-derived clock only once supplies are settled and the oscillator is stable.
// - After a wake start the controller must raise primary enable, or 100 us after the clock switch-over the device falls back to complete power down.
// - Primary enable raised during a wake start keeps the device active with no time-out.
// - Control-register mode bits act only while primary enable is high; otherwise the pins alone decide the state.
// - Bit 7 of register 00 selects standby with low-power regulators and running clock, left for full operation within 100 us.
// - Bits 7, 5 and 1 all clear run regulators and oscillator with the RF section off, left for full operation within 25 us.
// - Bit 1 set with bits 7 and 5 clear turns on only the RF receiver.
// - Bit 5 set with bit 7 clear turns on receiver and transmitter, at half power when bit 4 is 1 and full power when it is 0.
package rpmc_pkg;

    // Clock rate of ref_clk.
    localparam int unsigned CLK_HZ = 20_000_000;

    // Register offsets; the status register is read-only.
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h01;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // Field positions in the control register.
    localparam int unsigned BIT_STANDBY = 7;
    localparam int unsigned BIT_RF_ON = 5;
    localparam int unsigned BIT_HALF_PWR = 4;
    localparam int unsigned BIT_RX_ONLY = 1;

    // Times in their own units and cycle counts derived from them.
    localparam int unsigned AUX_CLK_HZ = 60_000;
    localparam int unsigned AUX_HALF_CYC = CLK_HZ / (2 * AUX_CLK_HZ);
    localparam int unsigned CONFIRM_US = 100;
    localparam int unsigned CONFIRM_CYC = CONFIRM_US * (CLK_HZ / 1_000_000);
    localparam int unsigned LOW_POWER_HOLD_WAKE_US = 100;
    localparam int unsigned LOW_POWER_HOLD_WAKE_CYC = LOW_POWER_HOLD_WAKE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned RFOFF_WAKE_US = 25;
    localparam int unsigned RFOFF_WAKE_CYC =
        RFOFF_WAKE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CNT_W = 12;

    // Sequencer states, one-hot.
    typedef enum logic [4:0] {
        RPMC_OFF = 5'h01,
        RPMC_PARTIAL = 5'h02,
        RPMC_START = 5'h04,
        RPMC_CONFIRM = 5'h08,
        RPMC_ACTIVE = 5'h10
    } rpmc_state_t;

    // Reported power state codes.
    localparam logic [2:0] PS_POWER_DOWN = 3'h0;
    localparam logic [2:0] PS_PARTIAL = 3'h1;
    localparam logic [2:0] PS_STANDBY = 3'h2;
    localparam logic [2:0] PS_RF_OFF = 3'h3;
    localparam logic [2:0] PS_RX_ONLY = 3'h4;
    localparam logic [2:0] PS_TX_HALF = 3'h5;
    localparam logic [2:0] PS_TX_FULL = 3'h6;

endpackage

// >>> rtl/rpmc_top.sv
// Reader power-mode sequencer with its control and status registers.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module rpmc_top #(
    parameter int unsigned CONFIRM_CYCLES = rpmc_pkg::CONFIRM_CYC,
    parameter int unsigned LOW_POWER_HOLD_CYCLES = rpmc_pkg::LOW_POWER_HOLD_WAKE_CYC,
    parameter int unsigned RFOFF_CYCLES = rpmc_pkg::RFOFF_WAKE_CYC,
    parameter int unsigned AUX_HALF = rpmc_pkg::AUX_HALF_CYC,
    parameter int unsigned XTAL_HALF = 1
) (
    // Clock, reset and clock enable.
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    // Enable pins from the controller.
    input wire logic reader_enable,
    input wire logic wake_aux_enable,
    // Analog readiness indications.
    input wire logic supply_settled,
    input wire logic osc_stable,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Power controls toward the analog front end.
    output logic regulators_on,
    output logic regulators_low_power,
    output logic aux_supply_on,
    output logic osc_on,
    output logic rx_enable,
    output logic tx_enable,
    output logic tx_half_power,
    output logic mcu_clock_output,
    output logic [2:0] power_state
);

    logic en_meta;
    logic en_sync;
    logic wake_meta;
    logic wake_sync;
    logic wake_prev;
    logic [7:0] power_and_chip_control;
    rpmc_pkg::rpmc_state_t state;
    rpmc_pkg::rpmc_state_t next_state;
    logic [rpmc_pkg::CNT_W-1:0] confirm_cnt;
    logic [rpmc_pkg::CNT_W-1:0] recover_cnt;
    logic [7:0] clk_cnt;
    logic ready;
    logic recovering;
    logic [2:0] next_mode;
    logic [2:0] prev_mode;
    logic next_rx;
    logic next_tx;
    logic next_half;

    // Two-stage synchronisers on both enable pins.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            en_meta <= 1'b0;
            en_sync <= 1'b0;
            wake_meta <= 1'b0;
            wake_sync <= 1'b0;
            wake_prev <= 1'b0;
        end else if (clk_en) begin
            en_meta <= reader_enable;
            en_sync <= en_meta;
            wake_meta <= wake_aux_enable;
            wake_sync <= wake_meta;
            wake_prev <= wake_sync;
        end
    end

    // Both analog indications must hold before the crystal clock is used.
    assign ready = supply_settled && osc_stable;

    // Control register written over the register port.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            power_and_chip_control <= rpmc_pkg::CONTROL_RESET;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == rpmc_pkg::ADDR_CONTROL) begin
                power_and_chip_control <= reg_wdata;
            end
        end
    end

    // Read data appear the cycle after the read strobe.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            if (reg_rd && reg_addr == rpmc_pkg::ADDR_CONTROL) begin
                reg_rdata <= power_and_chip_control;
            end else if (reg_rd && reg_addr == rpmc_pkg::ADDR_STATUS) begin
                reg_rdata <= {osc_stable, supply_settled, recovering,
                    state == rpmc_pkg::RPMC_CONFIRM, 1'b0, power_state};
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // Next sequencer state from the pins and readiness.
    always_comb begin
        next_state = state;
        unique case (state)
            rpmc_pkg::RPMC_OFF: begin
                if (en_sync) begin
                    next_state = rpmc_pkg::RPMC_START;
                end else if (wake_sync && !wake_prev) begin
                    next_state = rpmc_pkg::RPMC_START;
                end else if (wake_sync) begin
                    next_state = rpmc_pkg::RPMC_PARTIAL;
                end
            end
            rpmc_pkg::RPMC_PARTIAL: begin
                if (en_sync) begin
                    next_state = rpmc_pkg::RPMC_START;
                end else if (!wake_sync) begin
                    next_state = rpmc_pkg::RPMC_OFF;
                end
            end
            rpmc_pkg::RPMC_START: begin
                if (ready) begin
                    next_state = en_sync ? rpmc_pkg::RPMC_ACTIVE
                        : rpmc_pkg::RPMC_CONFIRM;
                end
            end
            rpmc_pkg::RPMC_CONFIRM: begin
                if (en_sync) begin
                    next_state = rpmc_pkg::RPMC_ACTIVE;
                end else if (confirm_cnt ==
                    rpmc_pkg::CNT_W'(CONFIRM_CYCLES - 1)) begin
                    next_state = rpmc_pkg::RPMC_OFF;
                end
            end
            rpmc_pkg::RPMC_ACTIVE: begin
                if (!en_sync) begin
                    next_state = wake_sync ? rpmc_pkg::RPMC_PARTIAL
                        : rpmc_pkg::RPMC_OFF;
                end
            end
            default: begin
                next_state = rpmc_pkg::RPMC_OFF;
            end
        endcase
    end

    // State register.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= rpmc_pkg::RPMC_OFF;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // Confirmation time-out counted in ref_clk cycles.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            confirm_cnt <= '0;
        end else if (clk_en) begin
            if (state == rpmc_pkg::RPMC_CONFIRM) begin
                confirm_cnt <= confirm_cnt + 1'b1;
            end else begin
                confirm_cnt <= '0;
            end
        end
    end

    // Mode decode of the control bits, used only while fully active.
    always_comb begin
        next_mode = rpmc_pkg::PS_POWER_DOWN;
        next_rx = 1'b0;
        next_tx = 1'b0;
        next_half = 1'b0;
        if (state == rpmc_pkg::RPMC_ACTIVE && en_sync) begin
            if (power_and_chip_control[rpmc_pkg::BIT_STANDBY]) begin
                next_mode = rpmc_pkg::PS_STANDBY;
            end else if (power_and_chip_control[rpmc_pkg::BIT_RF_ON]) begin
                next_rx = 1'b1;
                next_tx = 1'b1;
                next_half =
                    power_and_chip_control[rpmc_pkg::BIT_HALF_PWR];
                next_mode = next_half ? rpmc_pkg::PS_TX_HALF
                    : rpmc_pkg::PS_TX_FULL;
            end else if (power_and_chip_control[rpmc_pkg::BIT_RX_ONLY]) begin
                next_rx = 1'b1;
                next_mode = rpmc_pkg::PS_RX_ONLY;
            end else begin
                next_mode = rpmc_pkg::PS_RF_OFF;
            end
        end else if (state == rpmc_pkg::RPMC_PARTIAL) begin
            next_mode = rpmc_pkg::PS_PARTIAL;
        end
    end

    // Recovery from standby or RF-off holds the RF section briefly off.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            recover_cnt <= '0;
            recovering <= 1'b0;
            prev_mode <= rpmc_pkg::PS_POWER_DOWN;
        end else if (clk_en) begin
            prev_mode <= next_mode;
            if (next_rx && prev_mode == rpmc_pkg::PS_STANDBY) begin
                recover_cnt <= rpmc_pkg::CNT_W'(LOW_POWER_HOLD_CYCLES - 1);
                recovering <= 1'b1;
            end else if (next_rx && prev_mode == rpmc_pkg::PS_RF_OFF) begin
                recover_cnt <= rpmc_pkg::CNT_W'(RFOFF_CYCLES - 1);
                recovering <= 1'b1;
            end else if (!next_rx) begin
                recover_cnt <= '0;
                recovering <= 1'b0;
            end else if (recover_cnt != '0) begin
                recover_cnt <= recover_cnt - 1'b1;
            end else begin
                recovering <= 1'b0;
            end
        end
    end

    // Analog controls follow the state and the decoded mode.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            regulators_on <= 1'b0;
            regulators_low_power <= 1'b0;
            aux_supply_on <= 1'b0;
            osc_on <= 1'b0;
            rx_enable <= 1'b0;
            tx_enable <= 1'b0;
            tx_half_power <= 1'b0;
            power_state <= rpmc_pkg::PS_POWER_DOWN;
        end else if (clk_en) begin
            regulators_on <= state != rpmc_pkg::RPMC_OFF
                && state != rpmc_pkg::RPMC_PARTIAL;
            osc_on <= state != rpmc_pkg::RPMC_OFF
                && state != rpmc_pkg::RPMC_PARTIAL;
            aux_supply_on <= state != rpmc_pkg::RPMC_OFF;
            regulators_low_power <=
                next_mode == rpmc_pkg::PS_STANDBY;
            // The recovery flag lands one edge late, so the entry cycle is
            // masked from the previous mode to avoid a one-cycle RF pulse.
            rx_enable <= next_rx && !recovering
                && prev_mode != rpmc_pkg::PS_STANDBY
                && prev_mode != rpmc_pkg::PS_RF_OFF;
            tx_enable <= next_tx && !recovering
                && prev_mode != rpmc_pkg::PS_STANDBY
                && prev_mode != rpmc_pkg::PS_RF_OFF;
            tx_half_power <= next_half;
            power_state <= next_mode;
        end
    end

    // Controller clock: off, 60 kHz auxiliary, or crystal-derived.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            clk_cnt <= 8'h00;
            mcu_clock_output <= 1'b0;
        end else if (clk_en) begin
            if (state == rpmc_pkg::RPMC_OFF) begin
                clk_cnt <= 8'h00;
                mcu_clock_output <= 1'b0;
            end else if (state == rpmc_pkg::RPMC_ACTIVE
                || state == rpmc_pkg::RPMC_CONFIRM) begin
                if (clk_cnt >= 8'(XTAL_HALF - 1)) begin
                    clk_cnt <= 8'h00;
                    mcu_clock_output <= !mcu_clock_output;
                end else begin
                    clk_cnt <= clk_cnt + 1'b1;
                end
            end else begin
                if (clk_cnt >= 8'(AUX_HALF - 1)) begin
                    clk_cnt <= 8'h00;
                    mcu_clock_output <= !mcu_clock_output;
                end else begin
                    clk_cnt <= clk_cnt + 1'b1;
                end
            end
        end
    end

endmodule

// >>> test/rpmc_mcu.sv
// Controller model driving the enable pins and the register port.
`timescale 1ns/1ps
module rpmc_mcu (
    // Clock.
    input wire logic ref_clk,
    // Enable pins.
    output logic reader_enable,
    output logic wake_aux_enable,
    // Register port.
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    // Pins low and the port idle from time zero.
    initial begin
        reader_enable = 1'b0;
        wake_aux_enable = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Sets both pins just after a rising edge; a late or absent primary
    // enable is how the controller lets a wake start lapse.
    task automatic pins(input logic en, input logic wk);
        @(posedge ref_clk);
        reader_enable <= en;
        wake_aux_enable <= wk;
    endtask
    // One-cycle pulse on the wake pin, as from a push-button.
    task automatic wake_pulse();
        pins(1'b0, 1'b1);
        pins(1'b0, 1'b0);
    endtask
    // One-cycle write strobe.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // One-cycle read strobe; data is taken in the following cycle.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule

// >>> test/rpmc_sva.sv
// Port assertions for the reader power-mode control.
`timescale 1ns/1ps
module rpmc_sva #(
    parameter int unsigned LOW_POWER_HOLD_CYCLES = 20
) (
    // Clock, reset and register port.
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Power controls.
    input wire logic regulators_on,
    input wire logic regulators_low_power,
    input wire logic aux_supply_on,
    input wire logic osc_on,
    input wire logic rx_enable,
    input wire logic tx_enable,
    input wire logic tx_half_power,
    input wire logic mcu_clock_output,
    input wire logic [2:0] power_state
);
    // Longest wait for the receiver after a mode change.
    localparam int RECOV_MAX = LOW_POWER_HOLD_CYCLES + 8;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    // A state held three edges, so the registered outputs have caught up.
    sequence s_held(logic [2:0] st);
        (power_state == st) [*3];
    endsequence
    a_down_quiet: assert property (!aux_supply_on [*2] |->
        !regulators_on && !osc_on && !mcu_clock_output)
        else $error("supply or clock active in complete power down");
    a_partial_aux: assert property (s_held(rpmc_pkg::PS_PARTIAL) |->
        aux_supply_on && !regulators_on && !rx_enable)
        else $error("partial power down outputs wrong");
    a_standby_lowpwr: assert property (s_held(rpmc_pkg::PS_STANDBY) |->
        regulators_low_power && osc_on && !rx_enable && !tx_enable)
        else $error("standby outputs wrong");
    a_rfoff_quiet: assert property (s_held(rpmc_pkg::PS_RF_OFF) |->
        regulators_on && osc_on && !rx_enable && !tx_enable)
        else $error("rf-off outputs wrong");
    a_rxonly_no_tx: assert property (s_held(rpmc_pkg::PS_RX_ONLY) |->
        !tx_enable && !regulators_low_power)
        else $error("transmitter on in receive-only state");
    a_half_marked: assert property (s_held(rpmc_pkg::PS_TX_HALF) |->
        tx_half_power)
        else $error("half power not set");
    a_full_unmarked: assert property (s_held(rpmc_pkg::PS_TX_FULL) |->
        !tx_half_power)
        else $error("half power set in full power state");
    a_tx_in_mode: assert property (tx_enable |->
        power_state >= rpmc_pkg::PS_TX_HALF ||
        $past(power_state) >= rpmc_pkg::PS_TX_HALF)
        else $error("transmitter on outside transmit states");
    a_crystal_clock: assert property (s_held(rpmc_pkg::PS_TX_FULL) |->
        mcu_clock_output != $past(mcu_clock_output))
        else $error("clock output not at crystal rate");
    a_rx_recover: assert property (
        $rose(power_state == rpmc_pkg::PS_RX_ONLY) |->
        ##[1:RECOV_MAX] rx_enable)
        else $error("receiver late after mode change");
    a_rdata_idle: assert property ($past(clk_en) && !$past(reg_rd) |->
        reg_rdata == 8'h00)
        else $error("read data outside the answer cycle");
    a_status_live: assert property ($past(reg_rd) &&
        $past(reg_addr) == rpmc_pkg::ADDR_STATUS |->
        reg_rdata[2:0] == $past(power_state))
        else $error("status state field wrong");
endmodule

bind rpmc_top rpmc_sva #(.LOW_POWER_HOLD_CYCLES(LOW_POWER_HOLD_CYCLES)) u_sva (
    .ref_clk, .srst, .clk_en, .reg_addr, .reg_rd, .reg_rdata,
    .regulators_on, .regulators_low_power, .aux_supply_on, .osc_on,
    .rx_enable, .tx_enable, .tx_half_power, .mcu_clock_output,
    .power_state
);

// >>> test/testbench.sv
// Self-checking bench of the reader power-mode control.
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic supply_settled = 1'b0;
    logic osc_stable = 1'b0;
    logic reader_enable, wake_aux_enable, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
    logic regulators_on, regulators_low_power, aux_supply_on, osc_on;
    logic rx_enable, tx_enable, tx_half_power, mcu_clock_output;
    logic [2:0] power_state;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int k;
    // Mode bytes with the expected controls and state codes.
    logic [7:0] modes [7] = '{8'hA2, 8'h02, 8'h30, 8'h20, 8'h80, 8'h00, 8'h12};
    logic [7:0] outs [7] = '{8'hF0, 8'hB8, 8'hBE, 8'hBC, 8'hF0, 8'hB0, 8'hB8};
    logic [7:0] codes [7] = '{8'h02, 8'h04, 8'h05, 8'h06, 8'h02, 8'h03, 8'h04};
    // Clock of 50 ns period.
    always #25 ref_clk = ~ref_clk;
    rpmc_top #(.CONFIRM_CYCLES(20), .LOW_POWER_HOLD_CYCLES(20), .RFOFF_CYCLES(5),
        .AUX_HALF(4)) u_dut (.ref_clk, .srst, .clk_en(1'b1), .reader_enable,
        .wake_aux_enable, .supply_settled, .osc_stable, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .regulators_on,
        .regulators_low_power, .aux_supply_on, .osc_on, .rx_enable,
        .tx_enable, .tx_half_power, .mcu_clock_output, .power_state);
    rpmc_mcu u_mcu (.ref_clk, .reader_enable, .wake_aux_enable, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    // Prints the verdict and ends the run.
    task automatic give_verdict();
        if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Compares one byte and reports a mismatch at once.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Waits n edges, then lets their updates land.
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Drives both analog readiness inputs.
    task automatic sup(input logic v);
        @(posedge ref_clk);
        supply_settled <= v;
        osc_stable <= v;
    endtask
    // Counts clock output changes over n cycles.
    task automatic togs(input int n, input int exp);
        int t;
        logic p;
        t = 0;
        p = mcu_clock_output;
        repeat (n) begin
            w(1);
            if (mcu_clock_output !== p) t++;
            p = mcu_clock_output;
        end
        chk(8'(t), 8'(exp));
    endtask
    // Packs the power controls into one byte.
    function automatic logic [7:0] pw();
        return {regulators_on, regulators_low_power, aux_supply_on, osc_on,
            rx_enable, tx_enable, tx_half_power, 1'b0};
    endfunction
    // Cuts a hung run short.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            give_verdict();
        end
    end
    // Main sequence.
    initial begin
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        w(1);
        chk(pw(), 8'h00);
        togs(16, 0);
        u_mcu.rd(8'h00, rd_val);
        chk(rd_val, 8'h00);
        u_mcu.pins(1'b0, 1'b1);
        u_mcu.wr(8'h00, 8'h20);
        w(8);
        chk(pw(), 8'hB0);
        chk({5'h00, power_state}, 8'h00);
        togs(40, 10);
        sup(1'b1);
        u_mcu.pins(1'b1, 1'b0);
        w(30);
        chk({5'h00, power_state}, 8'h06);
        togs(10, 10);
        for (int i = 0; i < 7; i++) begin
            u_mcu.wr(8'h00, modes[i]);
            w(30);
            chk(pw(), outs[i]);
            chk({5'h00, power_state}, codes[i]);
        end
        u_mcu.wr(8'h01, 8'hFF);
        u_mcu.rd(8'h00, rd_val);
        chk(rd_val, 8'h12);
        u_mcu.rd(8'h01, rd_val);
        chk(rd_val, 8'hC4);
        u_mcu.rd(8'h05, rd_val);
        chk(rd_val, 8'h00);
        // Partial power down: wake pin raised at the same edge as the primary enable drops.
        u_mcu.pins(1'b0, 1'b1);
        w(8);
        chk(pw(), 8'h20);
        chk({5'h00, power_state}, 8'h01);
        togs(16, 4);
        u_mcu.pins(1'b0, 1'b0);
        w(8);
        chk(pw(), 8'h00);
        // Wake pulse that the controller never confirms.
        sup(1'b0);
        u_mcu.wake_pulse();
        w(8);
        chk(pw(), 8'hB0);
        togs(8, 2);
        sup(1'b1);
        k = 0;
        while (osc_on === 1'b1 && k < 100) begin
            w(1);
            k++;
        end
        chk({7'h00, k >= 20 && k <= 30}, 8'h01);
        // Wake pulse confirmed by the primary enable.
        sup(1'b0);
        u_mcu.wake_pulse();
        w(8);
        sup(1'b1);
        w(3);
        togs(4, 4);
        u_mcu.pins(1'b1, 1'b0);
        w(40);
        chk({5'h00, power_state}, 8'h04);
        give_verdict();
    end
endmodule
